// ==== hdl/host_port_pkg.sv ====
// Shared constants for both ends of the host port
package host_port_pkg;

	// Register bank and bus widths
	localparam int NUM_REGS = 17;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 8;
	localparam int NUM_CHAN = 2;
	localparam logic [ADDR_W-1:0] ADDR_LIMIT = ADDR_W'(NUM_REGS);

	// Serial frame: read flag, address, data, check bit, MSB first
	localparam int FRAME_BITS = 15;
	localparam logic [3:0] FRAME_LAST = 4'(FRAME_BITS - 1);
	localparam logic [3:0] ADDR_LAST = 4'h5;
	localparam int FR_READ = 14;
	localparam int FR_ADDR_LSB = 9;
	localparam int FR_DATA_LSB = 1;
	localparam int FR_CHECK = 0;

	// Device pin sample vector layout
	localparam int IX_P3 = 0;
	localparam int IX_P4 = 1;
	localparam int IX_P5 = 2;
	localparam int IX_P6 = 3;
	localparam int IX_P7 = 4;
	localparam int IX_P8 = 5;
	localparam int IX_P9 = 6;
	localparam int IX_P10 = 7;
	localparam int IX_DATA = 8;
	localparam int IX_PTY = 16;
	localparam int IX_MODE_A = 17;
	localparam int DSYNC_W = 19;

	// Host sample vector layout
	localparam int HX_ACK = 0;
	localparam int HX_MISO_A = 1;
	localparam int HX_MISO_B = 2;
	localparam int HX_DATA = 3;
	localparam int HX_PTY = 11;
	localparam int HSYNC_W = 12;

	// Timing, in ns at the host clock rate
	localparam int REF_MHZ = 250;
	localparam int LINK_HALF_NS = 64;
	localparam int PAR_SETUP_NS = 384;
	localparam int PAR_STROBE_NS = 1024;
	localparam int PAR_HOLD_NS = 768;
	localparam int SER_HALF_NS = 512;
	localparam int SER_TAIL_NS = 768;
	localparam int DEV_RST_NS = 1024;

	// Least times round up to whole cycles, never below one
	function automatic int to_cyc(input int ns);
		int c;
		c = (ns * REF_MHZ + 999) / 1000;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int CNT_W = 9;
	localparam logic [CNT_W-1:0] LINK_HALF_LOAD = CNT_W'(to_cyc(LINK_HALF_NS) - 1);
	localparam logic [CNT_W-1:0] PAR_SETUP_LOAD = CNT_W'(to_cyc(PAR_SETUP_NS) - 1);
	localparam logic [CNT_W-1:0] PAR_STROBE_LOAD = CNT_W'(to_cyc(PAR_STROBE_NS) - 1);
	localparam logic [CNT_W-1:0] PAR_HOLD_LOAD = CNT_W'(to_cyc(PAR_HOLD_NS) - 1);
	localparam logic [CNT_W-1:0] SER_HALF_LOAD = CNT_W'(to_cyc(SER_HALF_NS) - 1);
	localparam logic [CNT_W-1:0] SER_TAIL_LOAD = CNT_W'(to_cyc(SER_TAIL_NS) - 1);
	localparam logic [CNT_W-1:0] DEV_RST_LOAD = CNT_W'(to_cyc(DEV_RST_NS) - 1);

endpackage

// ==== hdl/host_port_if.sv ====
// Shared pins between the host and the telemetry controller port
`timescale 1ns/10ps
interface host_port_if;
	import host_port_pkg::*;

	// System clock, reset and mode straps, all driven by the host
	logic sys_clk;
	logic reset_n;
	logic mode_a_n;
	logic mode_b_n;
	// One-way shared pins from the host
	logic serial_sel_chan_a_n;
	logic serial_clk_chan_a;
	logic write_en_mosi_a;
	logic addr_bit_one;
	logic addr_bit_two;
	logic addr_bit_three;
	// Two-way pins: each party's value and enable, and the resolved wire
	logic a0_host, a0_host_oe, a0_dev, a0_dev_oe, addr_bit_zero;
	logic a4_host, a4_host_oe, a4_dev, a4_dev_oe, addr_bit_four;
	logic [DATA_W-1:0] data_host, data_dev, data;
	logic data_host_oe, data_dev_oe;
	logic pty_host, pty_host_oe, pty_dev, pty_dev_oe, even_check_bit;
	// Acknowledge from the device
	logic ack_n;

	// Weak pull-downs win only when nobody drives
	assign addr_bit_zero = a0_dev_oe ? a0_dev : (a0_host_oe & a0_host);
	assign addr_bit_four = a4_dev_oe ? a4_dev : (a4_host_oe & a4_host);
	assign data = data_dev_oe ? data_dev :
		(data_host_oe ? data_host : '0);
	assign even_check_bit = pty_dev_oe ? pty_dev : (pty_host_oe & pty_host);

	modport host (
		output sys_clk, reset_n, mode_a_n, mode_b_n,
		output serial_sel_chan_a_n, serial_clk_chan_a, write_en_mosi_a,
		output addr_bit_one, addr_bit_two, addr_bit_three,
		output a0_host, a0_host_oe, a4_host, a4_host_oe,
		output data_host, data_host_oe, pty_host, pty_host_oe,
		input addr_bit_zero, addr_bit_four, data, even_check_bit, ack_n
	);

	modport device (
		input sys_clk, reset_n, mode_a_n, mode_b_n,
		input serial_sel_chan_a_n, serial_clk_chan_a, write_en_mosi_a,
		input addr_bit_one, addr_bit_two, addr_bit_three,
		output a0_dev, a0_dev_oe, a4_dev, a4_dev_oe,
		output data_dev, data_dev_oe, pty_dev, pty_dev_oe, ack_n,
		input addr_bit_zero, addr_bit_four, data, even_check_bit
	);

endinterface

// ==== hdl/host_port_device.sv ====
// Controller end of the host port: pin roles, serial engines, register bank
`timescale 1ns/10ps
module host_port_device (
	// Link pins
	host_port_if.device link,
	// Register bank view
	output logic [host_port_pkg::NUM_REGS*host_port_pkg::DATA_W-1:0] bank_flat,
	// Update report
	output logic upd_valid,
	output logic [host_port_pkg::ADDR_W-1:0] upd_addr,
	output logic [host_port_pkg::DATA_W-1:0] upd_data,
	output logic err_pulse
);
	import host_port_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Input synchronisers
	logic rst_meta;
	logic rst_n;
	logic [DSYNC_W-1:0] pin_raw;
	logic [DSYNC_W-1:0] pin_meta;
	logic [DSYNC_W-1:0] pin_sync;

	assign pin_raw = {link.mode_b_n, link.mode_a_n, link.even_check_bit,
		link.data, link.addr_bit_four, link.addr_bit_three,
		link.addr_bit_two, link.addr_bit_one, link.addr_bit_zero,
		link.write_en_mosi_a, link.serial_clk_chan_a,
		link.serial_sel_chan_a_n};

	// Everything here lives on the supplied system clock
	always_ff @(posedge link.sys_clk) begin
		rst_meta <= link.reset_n;
		rst_n <= rst_meta;
		pin_meta <= pin_raw;
		pin_sync <= pin_meta;
	end

	////////////////////////////////////////////////////////////////////////
	// Register bank
	logic [DATA_W-1:0] bank [NUM_REGS];

	function automatic logic [DATA_W-1:0] rd_byte(
		input logic [ADDR_W-1:0] a);
		return (a < ADDR_LIMIT) ? bank[a] : '0;
	endfunction

	for (genvar r = 0; r < NUM_REGS; r++) begin : g_view
		assign bank_flat[r*DATA_W +: DATA_W] = bank[r];
	end

	////////////////////////////////////////////////////////////////////////
	// Pin roles
	wire par_mode = pin_sync[IX_MODE_A] & pin_sync[IX_MODE_A+1];
	wire par_ce_n = pin_sync[IX_P3];
	wire par_oe_n = pin_sync[IX_P4];
	wire par_we_n = pin_sync[IX_P5];
	wire [ADDR_W-1:0] par_addr = pin_sync[IX_P10:IX_P6];
	wire [DATA_W-1:0] par_data = pin_sync[IX_DATA +: DATA_W];

	logic [NUM_CHAN-1:0] ch_en;
	logic [NUM_CHAN-1:0] ch_sel_n;
	logic [NUM_CHAN-1:0] ch_sclk;
	logic [NUM_CHAN-1:0] ch_mosi;
	logic [NUM_CHAN-1:0] ch_act;
	logic [NUM_CHAN-1:0] ch_done;
	logic [NUM_CHAN-1:0] ch_miso;
	logic [FRAME_BITS-1:0] ch_frame [NUM_CHAN];

	// Channel A on pins three to six, channel B on pins seven to ten
	assign ch_en = ~pin_sync[IX_MODE_A +: NUM_CHAN];
	assign ch_sel_n = {pin_sync[IX_P7], pin_sync[IX_P3]};
	assign ch_sclk = {pin_sync[IX_P8], pin_sync[IX_P4]};
	assign ch_mosi = {pin_sync[IX_P9], pin_sync[IX_P5]};

	////////////////////////////////////////////////////////////////////////
	// Serial engines, one per channel
	for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
		logic sclk_prev;
		logic [3:0] bit_cnt;
		logic [FRAME_BITS-1:0] rx;
		logic [DATA_W:0] tx;
		logic done;
		logic [ADDR_W-1:0] hdr_addr;
		logic [DATA_W-1:0] hdr_data;
		logic rise;

		assign ch_act[c] = ch_en[c] & ~ch_sel_n[c];
		assign rise = ch_act[c] & ch_sclk[c] & ~sclk_prev;
		assign hdr_addr = {rx[ADDR_W-2:0], ch_mosi[c]};
		// Direct select, so a bank write is seen without a new address
		assign hdr_data = (hdr_addr < ADDR_LIMIT) ? bank[hdr_addr] : '0;
		assign ch_done[c] = done;
		assign ch_frame[c] = rx;
		assign ch_miso[c] = tx[DATA_W];

		always_ff @(posedge link.sys_clk) begin
			if (!rst_n) begin
				sclk_prev <= 1'h0;
				bit_cnt <= 4'h0;
				rx <= '0;
				tx <= '0;
				done <= 1'h0;
			end else begin
				sclk_prev <= ch_sclk[c];
				done <= rise && (bit_cnt == FRAME_LAST);
				if (!ch_act[c]) begin
					bit_cnt <= 4'h0;
				end else if (rise && bit_cnt != FRAME_LAST + 4'h1) begin
					rx <= {rx[FRAME_BITS-2:0], ch_mosi[c]};
					bit_cnt <= bit_cnt + 4'h1;
					// Answer byte leaves MSB first, then its check bit
					if (bit_cnt == ADDR_LAST) begin
						tx <= {hdr_data, ^{hdr_addr, hdr_data}};
					end else if (bit_cnt > ADDR_LAST) begin
						tx <= {tx[DATA_W-1:0], 1'h0};
					end
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transfer completion and selection
	logic we_prev;
	logic ack_n;
	logic [DATA_W-1:0] par_rd;
	logic par_rd_chk;

	// Write is taken as the write strobe rises, data still held
	wire ev_par = par_mode & ~par_ce_n & par_we_n & ~we_prev;
	// Hosts never overlap, so one source per cycle; A is preferred
	wire [FRAME_BITS-1:0] ev_frame = ch_done[0] ? ch_frame[0] :
		ch_frame[1];
	wire ev_valid = ev_par | (|ch_done);
	wire ev_write = ev_par | ~ev_frame[FR_READ];
	wire [ADDR_W-1:0] ev_addr = ev_par ? par_addr :
		ev_frame[FR_ADDR_LSB +: ADDR_W];
	wire [DATA_W-1:0] ev_data = ev_par ? par_data :
		ev_frame[FR_DATA_LSB +: DATA_W];
	wire ev_chk = ev_par ? pin_sync[IX_PTY] : ev_frame[FR_CHECK];
	wire ev_ok = ~^{ev_addr, ev_data, ev_chk};
	wire bank_we = ev_valid & ev_ok & ev_write & (ev_addr < ADDR_LIMIT);

	always_ff @(posedge link.sys_clk) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				bank[i] <= '0;
			end
			we_prev <= 1'h1;
			ack_n <= 1'h0;
			upd_valid <= 1'h0;
			upd_addr <= '0;
			upd_data <= '0;
			err_pulse <= 1'h0;
		end else begin
			we_prev <= par_we_n;
			if (bank_we) begin
				bank[ev_addr] <= ev_data;
			end
			// A good parallel write or serial frame clears a previous failure
			if (ev_valid) begin
				ack_n <= ~ev_ok;
			end
			upd_valid <= bank_we;
			err_pulse <= ev_valid & ~ev_ok;
			if (bank_we) begin
				upd_addr <= ev_addr;
				upd_data <= ev_data;
			end
		end
	end

	// Read data tracks the address; driven only while read enable is low
	always_ff @(posedge link.sys_clk) begin
		if (!rst_n) begin
			par_rd <= '0;
			par_rd_chk <= 1'h0;
		end else begin
			par_rd <= rd_byte(par_addr);
			par_rd_chk <= ^{par_addr, rd_byte(par_addr)};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin drivers
	wire par_read = par_mode & ~par_ce_n & ~par_oe_n;

	assign link.data_dev = par_rd;
	assign link.data_dev_oe = par_read;
	assign link.pty_dev = par_rd_chk;
	assign link.pty_dev_oe = par_read;
	assign link.a0_dev = ch_miso[0];
	assign link.a0_dev_oe = ch_act[0];
	assign link.a4_dev = ch_miso[1];
	assign link.a4_dev_oe = ch_act[1];
	assign link.ack_n = ack_n;

endmodule

// ==== hdl/host_port_host.sv ====
// Host end of the port: clock divider, pin roles and transfer sequencer
`timescale 1ns/10ps
module host_port_host (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Mode straps passed to the device
	input wire logic mode_a_n,
	input wire logic mode_b_n,
	// Requests
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_read,
	input wire logic req_chan_b,
	input wire logic [host_port_pkg::ADDR_W-1:0] req_addr,
	input wire logic [host_port_pkg::DATA_W-1:0] req_data,
	// Answers
	output logic rsp_valid,
	output logic [host_port_pkg::DATA_W-1:0] rsp_data,
	output logic rsp_err,
	// Link pins
	host_port_if.host link
);
	import host_port_pkg::*;

	typedef enum logic [2:0] {
		IDLE, P_SETUP, P_STROBE, P_HOLD, S_LOW, S_HIGH, S_TAIL, DONE
	} state_e;

	////////////////////////////////////////////////////////////////////////
	// Link clock, device reset, straps and input synchroniser
	logic [CNT_W-1:0] div_cnt;
	logic link_clk;
	logic [CNT_W-1:0] rst_cnt;
	logic dev_rst_n;
	logic strap_a_n;
	logic strap_b_n;
	logic [HSYNC_W-1:0] in_meta;
	logic [HSYNC_W-1:0] in_sync;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			div_cnt <= '0;
			link_clk <= 1'h0;
			rst_cnt <= DEV_RST_LOAD;
			dev_rst_n <= 1'h0;
			strap_a_n <= 1'h1;
			strap_b_n <= 1'h1;
		end else begin
			div_cnt <= (div_cnt == LINK_HALF_LOAD) ? '0 : div_cnt + 1'h1;
			if (div_cnt == LINK_HALF_LOAD) begin
				link_clk <= ~link_clk;
			end
			// Device reset outlasts several link clock edges
			if (rst_cnt != '0) begin
				rst_cnt <= rst_cnt - 1'h1;
			end
			dev_rst_n <= (rst_cnt == '0);
			strap_a_n <= mode_a_n;
			strap_b_n <= mode_b_n;
		end
	end

	always_ff @(posedge ref_clk) begin
		in_meta <= {link.even_check_bit, link.data, link.addr_bit_four,
			link.addr_bit_zero, link.ack_n};
		in_sync <= in_meta;
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer
	state_e state;
	logic [CNT_W-1:0] cnt;
	logic [3:0] bit_idx;
	logic is_read;
	logic chan_b;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic [FRAME_BITS-1:0] tx;
	logic [FRAME_BITS-1:0] rx;
	logic rd_chk;
	logic ce_n, oe_n, we_n, d_oe, sel_n, sck;

	wire par_mode = strap_a_n & strap_b_n;
	wire use_b = ~strap_b_n & (strap_a_n | req_chan_b);
	wire [DATA_W-1:0] req_wdata = req_read ? '0 : req_data;
	wire req_chk = ^{req_addr, req_wdata};
	wire cnt_end = (cnt == '0);
	wire miso = chan_b ? in_sync[HX_MISO_B] : in_sync[HX_MISO_A];
	wire [DATA_W-1:0] got_data = par_mode ? in_sync[HX_DATA +: DATA_W] :
		rx[FR_DATA_LSB +: DATA_W];
	wire got_chk = par_mode ? in_sync[HX_PTY] : rx[FR_CHECK];
	// Judged on the captured byte: the bus is already released by DONE
	wire read_bad = is_read & (^{addr, rsp_data, rd_chk});
	wire ack_bad = ~(par_mode & is_read) & in_sync[HX_ACK];

	assign req_ready = (state == IDLE) & dev_rst_n;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state <= IDLE;
			cnt <= '0;
			bit_idx <= 4'h0;
			{is_read, chan_b} <= 2'h0;
			addr <= '0;
			wdata <= '0;
			tx <= '0;
			rx <= '0;
			{ce_n, oe_n, we_n, sel_n} <= 4'hf;
			{d_oe, sck} <= 2'h0;
			rsp_valid <= 1'h0;
			rsp_data <= '0;
			rsp_err <= 1'h0;
			rd_chk <= 1'h0;
		end else begin
			rsp_valid <= 1'h0;
			cnt <= cnt_end ? '0 : cnt - 1'h1;
			unique case (state)
			IDLE: begin
				if (req_valid && req_ready) begin
					is_read <= req_read;
					chan_b <= use_b;
					addr <= req_addr;
					wdata <= req_data;
					tx <= {req_read, req_addr, req_wdata, req_chk};
					bit_idx <= 4'h0;
					if (par_mode) begin
						ce_n <= 1'h0;
						d_oe <= ~req_read;
						cnt <= PAR_SETUP_LOAD;
						state <= P_SETUP;
					end else begin
						sel_n <= 1'h0;
						cnt <= SER_HALF_LOAD;
						state <= S_LOW;
					end
				end
			end
			P_SETUP: begin
				if (cnt_end) begin
					oe_n <= ~is_read;
					we_n <= is_read;
					cnt <= PAR_STROBE_LOAD;
					state <= P_STROBE;
				end
			end
			P_STROBE: begin
				if (cnt_end) begin
					{oe_n, we_n} <= 2'h3;
					rsp_data <= got_data;
					rd_chk <= got_chk;
					cnt <= PAR_HOLD_LOAD;
					state <= P_HOLD;
				end
			end
			P_HOLD: begin
				if (cnt_end) begin
					ce_n <= 1'h1;
					d_oe <= 1'h0;
					state <= DONE;
				end
			end
			S_LOW: begin
				if (cnt_end) begin
					sck <= 1'h1;
					rx <= {rx[FRAME_BITS-2:0], miso};
					cnt <= SER_HALF_LOAD;
					state <= S_HIGH;
				end
			end
			S_HIGH: begin
				if (cnt_end) begin
					sck <= 1'h0;
					tx <= {tx[FRAME_BITS-2:0], 1'h0};
					bit_idx <= bit_idx + 4'h1;
					cnt <= (bit_idx == FRAME_LAST) ? SER_TAIL_LOAD :
						SER_HALF_LOAD;
					state <= (bit_idx == FRAME_LAST) ? S_TAIL : S_LOW;
				end
			end
			S_TAIL: begin
				sel_n <= 1'h1;
				if (cnt_end) begin
					rsp_data <= got_data;
					rd_chk <= got_chk;
					state <= DONE;
				end
			end
			DONE: begin
				rsp_valid <= 1'h1;
				rsp_err <= ack_bad | read_bad;
				state <= IDLE;
			end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin roles follow the straps
	wire mosi = tx[FRAME_BITS-1];

	assign link.sys_clk = link_clk;
	assign link.reset_n = dev_rst_n;
	assign link.mode_a_n = strap_a_n;
	assign link.mode_b_n = strap_b_n;
	assign link.serial_sel_chan_a_n = strap_a_n ? ce_n : (chan_b | sel_n);
	assign link.serial_clk_chan_a = strap_a_n ? oe_n : (~chan_b & sck);
	assign link.write_en_mosi_a = strap_a_n ? we_n : (~chan_b & mosi);
	assign link.a0_host = addr[0];
	assign link.a0_host_oe = strap_a_n;
	assign link.addr_bit_one = strap_b_n ? addr[1] : (~chan_b | sel_n);
	assign link.addr_bit_two = strap_b_n ? addr[2] : (chan_b & sck);
	assign link.addr_bit_three = strap_b_n ? addr[3] : (chan_b & mosi);
	assign link.a4_host = addr[ADDR_W-1];
	assign link.a4_host_oe = strap_b_n;
	assign link.data_host = wdata;
	assign link.data_host_oe = d_oe;
	assign link.pty_host = ^{addr, wdata};
	assign link.pty_host_oe = d_oe;

endmodule

// ==== verification/host_port_mode_select_sva.sv ====
// Checker for the shared pins between the host and device ends
`timescale 1ns/10ps
module host_port_mode_select_sva (
	// Clock, reset and straps
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic mode_a_n,
	input wire logic mode_b_n,
	// Shared pins
	input wire logic serial_sel_chan_a_n,
	input wire logic serial_clk_chan_a,
	input wire logic write_en_mosi_a,
	input wire logic addr_bit_zero,
	input wire logic addr_bit_one,
	input wire logic addr_bit_two,
	input wire logic addr_bit_three,
	input wire logic addr_bit_four,
	input wire logic [host_port_pkg::DATA_W-1:0] data,
	input wire logic even_check_bit,
	// Device drive parts
	input wire logic [host_port_pkg::DATA_W-1:0] data_dev,
	input wire logic data_dev_oe,
	input wire logic pty_dev,
	input wire logic a0_dev_oe,
	input wire logic a4_dev_oe,
	input wire logic ack_n
);
	import host_port_pkg::*;
	wire logic par_mode;
	wire logic strobe;
	wire logic [ADDR_W-1:0] addr_pins;
	assign par_mode = mode_a_n & mode_b_n;
	assign strobe = !serial_clk_chan_a || !write_en_mosi_a;
	assign addr_pins = {addr_bit_four, addr_bit_three, addr_bit_two,
		addr_bit_one, addr_bit_zero};
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	//////////////////////////////////////////////////////////////////////
	chk_par_oe_mode: assert property (
		data_dev_oe |-> par_mode) else $error("data driven outside parallel");
	chk_read_parity: assert property (
		data_dev_oe && $past(data_dev_oe) |->
		^{addr_pins, data_dev, pty_dev} == 1'b0) else $error("bad read check");
	chk_write_parity: assert property (
		par_mode && !serial_sel_chan_a_n && !write_en_mosi_a |->
		^{addr_pins, data, even_check_bit} == 1'b0) else $error("bad wr check");
	chk_read_release: assert property (
		$rose(serial_clk_chan_a) && par_mode |-> ##[0:5] !data_dev_oe)
		else $error("data held after read strobe");
	chk_miso_a_role: assert property (
		a0_dev_oe |-> !mode_a_n) else $error("pin six driven off channel A");
	chk_miso_b_role: assert property (
		a4_dev_oe |-> !mode_b_n) else $error("pin ten driven off channel B");
	chk_one_channel: assert property (
		!(a0_dev_oe && a4_dev_oe)) else $error("both channels drive");
	chk_ack_clean: assert property (
		!ack_n) else $error("acknowledge high on clean traffic");
	chk_strobe_idle: assert property (
		par_mode && serial_sel_chan_a_n |->
		serial_clk_chan_a && write_en_mosi_a) else $error("strobe while idle");
	chk_addr_steady: assert property (
		par_mode && strobe && $past(strobe) |-> $stable(addr_pins))
		else $error("address moved under strobe");
	chk_reset_quiet: assert property (disable iff (1'b0)
		!reset_n [*5] |-> !data_dev_oe && !a0_dev_oe && !a4_dev_oe && !ack_n)
		else $error("device active in reset");
	cov_par_read: cover property (data_dev_oe);
	cov_chan_a: cover property ($fell(serial_sel_chan_a_n) && !mode_a_n);
	cov_chan_b: cover property ($fell(addr_bit_one) && !mode_b_n);
endmodule

// ==== verification/tb_host_port_mode_select.sv ====
// Self-checking bench joining the host and device ends of the port
`timescale 1ns/10ps
module tb_host_port_mode_select;
	import host_port_pkg::*;
	logic ref_clk, rst_n, mode_a_n, mode_b_n, e;
	logic req_valid, req_ready, req_read, req_chan_b;
	logic rsp_valid, rsp_err, upd_valid, err_pulse;
	logic [ADDR_W-1:0] req_addr, upd_addr;
	logic [DATA_W-1:0] req_data, rsp_data, upd_data, q;
	logic [NUM_REGS*DATA_W-1:0] bank_flat;
	int error_cnt = 0;
	int check_count = 0;
	int err_seen = 0;
	int upd_seen = 0;
	host_port_if hp();
	host_port_host i_host_port_host (
		.ref_clk(ref_clk), .rst_n(rst_n),
		.mode_a_n(mode_a_n), .mode_b_n(mode_b_n),
		.req_valid(req_valid), .req_ready(req_ready), .req_read(req_read),
		.req_chan_b(req_chan_b), .req_addr(req_addr), .req_data(req_data),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_err(rsp_err),
		.link(hp)
	);
	host_port_device i_host_port_device (
		.link(hp), .bank_flat(bank_flat), .upd_valid(upd_valid),
		.upd_addr(upd_addr), .upd_data(upd_data), .err_pulse(err_pulse)
	);
	host_port_mode_select_sva i_host_port_mode_select_sva (
		.sys_clk(hp.sys_clk), .reset_n(hp.reset_n),
		.mode_a_n(hp.mode_a_n), .mode_b_n(hp.mode_b_n),
		.serial_sel_chan_a_n(hp.serial_sel_chan_a_n),
		.serial_clk_chan_a(hp.serial_clk_chan_a),
		.write_en_mosi_a(hp.write_en_mosi_a),
		.addr_bit_zero(hp.addr_bit_zero), .addr_bit_one(hp.addr_bit_one),
		.addr_bit_two(hp.addr_bit_two), .addr_bit_three(hp.addr_bit_three),
		.addr_bit_four(hp.addr_bit_four), .data(hp.data),
		.even_check_bit(hp.even_check_bit), .data_dev(hp.data_dev),
		.data_dev_oe(hp.data_dev_oe), .pty_dev(hp.pty_dev),
		.a0_dev_oe(hp.a0_dev_oe), .a4_dev_oe(hp.a4_dev_oe), .ack_n(hp.ack_n)
	);
	//////////////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	always @(posedge hp.sys_clk) begin
		if (err_pulse === 1'b1)
			err_seen++;
		if (upd_valid === 1'b1)
			upd_seen++;
	end
	task automatic cmp(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] x);
		check_count++;
		if (got !== x) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, x);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Ready is combinational, so it is only looked at on the falling edge
	task automatic wait_ready();
		int n;
		n = 0;
		while (req_ready !== 1'b1 && n < 2000) begin
			@(negedge ref_clk);
			n++;
		end
		cmp(8'(req_ready), 8'h01);
	endtask
	task automatic xfer(input logic rd, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d);
		int n;
		n = 0;
		wait_ready();
		@(posedge ref_clk);
		req_valid <= 1'b1;
		req_read <= rd;
		req_addr <= a;
		req_data <= d;
		@(posedge ref_clk);
		req_valid <= 1'b0;
		while (rsp_valid !== 1'b1 && n < 6000) begin
			@(negedge ref_clk);
			n++;
		end
		q = rsp_data;
		e = rsp_err;
		cmp(8'(rsp_valid), 8'h01);
	endtask
	// Straps pass two synchronisers, so let them settle while idle
	task automatic set_mode(input logic ma, input logic mb, input logic cb);
		@(posedge ref_clk);
		mode_a_n <= ma;
		mode_b_n <= mb;
		req_chan_b <= cb;
		repeat (64) @(posedge ref_clk);
	endtask
	//////////////////////////////////////////////////////////////////////
	task automatic t_par();
		logic [ADDR_W-1:0] a [3] = '{5'h10, 5'h00, 5'h05};
		logic [DATA_W-1:0] d [3] = '{8'h5A, 8'hA5, 8'h3C};
		set_mode(1'b1, 1'b1, 1'b0);
		foreach (a[i]) begin
			xfer(1'b0, a[i], d[i]);
			cmp(upd_data, d[i]);
			cmp(8'(upd_addr), 8'(a[i]));
			cmp(8'(e), 8'h00);
			xfer(1'b1, a[i], 8'h00);
			cmp(q, d[i]);
			cmp(8'(e), 8'h00);
			cmp(bank_flat[a[i]*8 +: 8], d[i]);
			cmp(8'(hp.ack_n), 8'h00);
		end
	endtask
	task automatic t_unmapped();
		xfer(1'b0, 5'h11, 8'hFF);
		cmp(bank_flat[16*8 +: 8], 8'h5A);
		xfer(1'b1, 5'h11, 8'h00);
		cmp(q, 8'h00);
		xfer(1'b1, 5'h1F, 8'h00);
		cmp(q, 8'h00);
	endtask
	task automatic t_serial(input logic cb, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d);
		set_mode(cb, ~cb, cb);
		xfer(1'b0, a, d);
		cmp(bank_flat[a*8 +: 8], d);
		xfer(1'b1, a, 8'h00);
		cmp(q, d);
		cmp(8'(e), 8'h00);
		cmp(8'(hp.ack_n), 8'h00);
		cmp(bank_flat[16*8 +: 8], 8'h5A);
	endtask
	// Both straps low: the one host writes on channel A, then reads back on channel B
	task automatic t_dual();
		set_mode(1'b0, 1'b0, 1'b0);
		xfer(1'b0, 5'h09, 8'h81);
		cmp(bank_flat[9*8 +: 8], 8'h81);
		set_mode(1'b0, 1'b0, 1'b1);
		xfer(1'b1, 5'h09, 8'h00);
		cmp(q, 8'h81);
		cmp(8'(e), 8'h00);
	endtask
	task automatic t_reset();
		set_mode(1'b1, 1'b1, 1'b0);
		@(posedge ref_clk);
		rst_n <= 1'b0;
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		wait_ready();
		cmp(8'(bank_flat !== '0), 8'h00);
		cmp(8'(hp.ack_n), 8'h00);
		xfer(1'b0, 5'h07, 8'hC3);
		xfer(1'b1, 5'h07, 8'h00);
		cmp(q, 8'hC3);
	endtask
	//////////////////////////////////////////////////////////////////////
	initial begin
		rst_n = 1'b0;
		mode_a_n = 1'b1;
		mode_b_n = 1'b1;
		req_valid = 1'b0;
		req_read = 1'b0;
		req_chan_b = 1'b0;
		req_addr = '0;
		req_data = '0;
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_par();
		t_unmapped();
		t_serial(1'b0, 5'h03, 8'h96);
		t_serial(1'b1, 5'h0E, 8'h69);
		t_dual();
		t_reset();
		cmp(8'(err_seen), 8'h00);
		// Seven writes land on mapped addresses over the whole run
		cmp(8'(upd_seen), 8'h07);
		end_sim();
	end
	// Whole run is about 32000 cycles; the limit leaves ample margin
	initial begin
		#240000;
		error_cnt++;
		end_sim();
	end
endmodule
